// ---- rtl/pts_consts.svh ----
`ifndef PTS_CONSTS_SVH
`define PTS_CONSTS_SVH

// Timestamp operation codes.
`define PTS_OP_NONE      2'h0
`define PTS_OP_ONESTEP   2'h1
`define PTS_OP_TWOSTEP   2'h2
`define PTS_OP_RESERVED  2'h3

// Time value layout: seconds above nanoseconds.
`define PTS_TIME_W       80
`define PTS_SEC_W        48
`define PTS_NS_W         32
`define PTS_TAG_W        16
`define PTS_OFS_W        16

// Transmit stamp queue.
`define PTS_Q_DEPTH      4
`define PTS_Q_IDX_W      2
`define PTS_Q_CNT_W      3
`define PTS_Q_W          96

// Register byte addresses.
`define PTS_ADDR_W       12
`define PTS_ADDR_CTRL    12'h000
`define PTS_ADDR_STATUS  12'h004
`define PTS_ADDR_DROPS   12'h008
`define PTS_ADDR_TXCNT   12'h00c

// Control register fields and reset value.
`define PTS_CTRL_TX_EN   0
`define PTS_CTRL_RX_EN   1
`define PTS_CTRL_OS_EN   2
`define PTS_CTRL_W       3
`define PTS_CTRL_RST     3'h7

`endif

// ---- rtl/pts_pkg.sv ----
`include "pts_consts.svh"

package pts_pkg;

  typedef enum logic [1:0] {
    PTS_OP_NONE_E    = `PTS_OP_NONE,
    PTS_OP_ONESTEP_E = `PTS_OP_ONESTEP,
    PTS_OP_TWOSTEP_E = `PTS_OP_TWOSTEP,
    PTS_OP_RSVD_E    = `PTS_OP_RESERVED
  } pts_op_e;

  typedef struct packed {
    logic [`PTS_SEC_W-1:0] sec;
    logic [`PTS_NS_W-1:0]  ns;
  } pts_time_s;

endpackage

// ---- rtl/pts_tag_queue.sv ----
`timescale 1ns/1ns
`include "pts_consts.svh"

// Small first-in first-out store of stamp and tag pairs, flip-flop based.
module pts_tag_queue (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   pclk_en,
  input  wire logic                   push,
  input  wire logic [`PTS_Q_W-1:0]    push_data,
  input  wire logic                   pop,
  output logic      [`PTS_Q_W-1:0]    head,
  output logic                        empty,
  output logic                        full
);

  logic [`PTS_Q_W-1:0]     mem_r [`PTS_Q_DEPTH];
  logic [`PTS_Q_W-1:0]     mem_nxt [`PTS_Q_DEPTH];
  logic [`PTS_Q_IDX_W-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [`PTS_Q_CNT_W-1:0] cnt_r, cnt_nxt;
  logic                    do_push, do_pop;

  assign empty   = (cnt_r == `PTS_Q_CNT_W'(0));
  assign full    = (cnt_r == `PTS_Q_CNT_W'(`PTS_Q_DEPTH));
  assign head    = mem_r[rd_r];
  assign do_pop  = pop && !empty;
  assign do_push = push && (!full || do_pop);

  always_comb begin
    mem_nxt = mem_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    cnt_nxt = cnt_r;
    if (do_push) begin
      mem_nxt[wr_r] = push_data;
      wr_nxt        = wr_r + `PTS_Q_IDX_W'(1);
    end
    if (do_pop) begin
      rd_nxt = rd_r + `PTS_Q_IDX_W'(1);
    end
    if (do_push && !do_pop) begin
      cnt_nxt = cnt_r + `PTS_Q_CNT_W'(1);
    end else if (do_pop && !do_push) begin
      cnt_nxt = cnt_r - `PTS_Q_CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `PTS_Q_DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else if (pclk_en) begin
      mem_r <= mem_nxt;
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule // pts_tag_queue

// ---- rtl/pts_top.sv ----
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "pts_consts.svh"

// Summary of operation
// - Op code 00 none, 01 one-step, 10 two-step, 11 acts as none.
// - With no operation the frame tag input is ignored entirely.
// - One-step and two-step frames capture the tag and return it with the stamp.
// - Transmit valid is high exactly while a valid stamp is presented.
// - Returned tag is 16 bits, the tag input bits 15:0 of that frame.
// - Transmit stamp is the time the frame start crossed the capture plane.
// - Receive stamp valid from the same cycle start of packet is seen.
// - Both stamps use the same bit format as the system timer.
// - Normal mode time is 48 bits seconds above 32 bits nanoseconds.
module pts_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    pclk_en,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`PTS_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic                         pready,
  output logic                         pslverr,
  output logic      [31:0]             prdata,
  input  wire logic [`PTS_TIME_W-1:0]  sys_time,
  input  wire logic                    tx_sop,
  input  wire logic [1:0]              timestamp_op_code,
  input  wire logic [`PTS_TAG_W-1:0]   tx_tag_in,
  input  wire logic [`PTS_OFS_W-1:0]   tx_ts_offset_in,
  input  wire logic [`PTS_OFS_W-1:0]   tx_csum_offset_in,
  input  wire logic                    tx_upd_csum_in,
  output logic                         tx_tstamp_valid,
  output logic      [`PTS_TIME_W-1:0]  tx_tstamp,
  output logic      [`PTS_TAG_W-1:0]   tx_tstamp_tag,
  output logic                         onestep_valid,
  output logic      [`PTS_TIME_W-1:0]  onestep_time,
  output logic      [`PTS_OFS_W-1:0]   onestep_ts_offset,
  output logic      [`PTS_OFS_W-1:0]   onestep_csum_offset,
  output logic                         onestep_upd_csum,
  input  wire logic                    rx_sop,
  output logic      [`PTS_TIME_W-1:0]  rx_tstamp
);

  ////////////////////////////////////////////////////////////////////////////
  // Operation decode.

  function automatic logic op_stamps(input logic [1:0] code);
    pts_pkg::pts_op_e op;
    op = pts_pkg::pts_op_e'(code);
    return (op == pts_pkg::PTS_OP_ONESTEP_E) || (op == pts_pkg::PTS_OP_TWOSTEP_E);
  endfunction

  // Splits a timer word into seconds and nanoseconds and rejoins it unchanged.
  function automatic logic [`PTS_TIME_W-1:0] as_time(input logic [`PTS_TIME_W-1:0] t);
    pts_pkg::pts_time_s s;
    s = pts_pkg::pts_time_s'(t);
    return {s.sec, s.ns};
  endfunction

  logic [`PTS_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic                   tx_en, rx_en, os_en;
  logic                   tx_take, os_take;

  assign tx_en   = ctrl_r[`PTS_CTRL_TX_EN];
  assign rx_en   = ctrl_r[`PTS_CTRL_RX_EN];
  assign os_en   = ctrl_r[`PTS_CTRL_OS_EN];
  assign tx_take = tx_en && tx_sop && op_stamps(timestamp_op_code);
  assign os_take = tx_take && os_en && (timestamp_op_code == `PTS_OP_ONESTEP);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit stamp queue: keeps frame order for stamp and tag.

  logic [`PTS_Q_W-1:0] q_head;
  logic                q_empty, q_full;

  pts_tag_queue u_queue (
    .pclk      (pclk),
    .presetn   (presetn),
    .pclk_en   (pclk_en),
    .push      (tx_take),
    .push_data ({as_time(sys_time), tx_tag_in}),
    .pop       (!q_empty),
    .head      (q_head),
    .empty     (q_empty),
    .full      (q_full)
  );

  logic                   txv_r, txv_nxt;
  logic [`PTS_TIME_W-1:0] txt_r, txt_nxt;
  logic [`PTS_TAG_W-1:0]  txg_r, txg_nxt;

  always_comb begin
    txv_nxt = !q_empty;
    txt_nxt = txt_r;
    txg_nxt = txg_r;
    if (!q_empty) begin
      txt_nxt = q_head[`PTS_Q_W-1:`PTS_TAG_W];
      txg_nxt = q_head[`PTS_TAG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txv_r <= 1'b0;
      txt_r <= '0;
      txg_r <= '0;
    end else if (pclk_en) begin
      txv_r <= txv_nxt;
      txt_r <= txt_nxt;
      txg_r <= txg_nxt;
    end
  end

  assign tx_tstamp_valid = txv_r;
  assign tx_tstamp       = txt_r;
  assign tx_tstamp_tag   = txg_r;

  ////////////////////////////////////////////////////////////////////////////
  // One-step insertion request toward the frame datapath.

  logic                   osv_r, osv_nxt, osu_r, osu_nxt;
  logic [`PTS_TIME_W-1:0] ost_r, ost_nxt;
  logic [`PTS_OFS_W-1:0]  oso_r, oso_nxt, osc_r, osc_nxt;

  always_comb begin
    osv_nxt = os_take;
    ost_nxt = ost_r;
    oso_nxt = oso_r;
    osc_nxt = osc_r;
    osu_nxt = osu_r;
    if (os_take) begin
      ost_nxt = as_time(sys_time);
      oso_nxt = tx_ts_offset_in;
      osc_nxt = tx_csum_offset_in;
      osu_nxt = tx_upd_csum_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osv_r <= 1'b0;
      ost_r <= '0;
      oso_r <= '0;
      osc_r <= '0;
      osu_r <= 1'b0;
    end else if (pclk_en) begin
      osv_r <= osv_nxt;
      ost_r <= ost_nxt;
      oso_r <= oso_nxt;
      osc_r <= osc_nxt;
      osu_r <= osu_nxt;
    end
  end

  assign onestep_valid       = osv_r;
  assign onestep_time        = ost_r;
  assign onestep_ts_offset   = oso_r;
  assign onestep_csum_offset = osc_r;
  assign onestep_upd_csum    = osu_r;

  ////////////////////////////////////////////////////////////////////////////
  // Receive stamp: follows the timer in the start cycle, then holds.

  logic [`PTS_TIME_W-1:0] rxt_r, rxt_nxt;
  logic                   rx_take;

  assign rx_take = rx_en && rx_sop;

  always_comb begin
    rxt_nxt = rx_take ? as_time(sys_time) : rxt_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxt_r <= '0;
    end else if (pclk_en) begin
      rxt_r <= rxt_nxt;
    end
  end

  assign rx_tstamp = rx_take ? as_time(sys_time) : rxt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Counters and last tag for software.

  logic [15:0]           drops_r, drops_nxt, txcnt_r, txcnt_nxt;
  logic [`PTS_TAG_W-1:0] last_tag_r, last_tag_nxt;
  logic                  drop;

  // A push into a full queue is lost only when nothing leaves that cycle.
  assign drop = tx_take && q_full && q_empty;

  always_comb begin
    drops_nxt    = drops_r + {15'h0, drop};
    txcnt_nxt    = txcnt_r + {15'h0, tx_take};
    last_tag_nxt = tx_take ? tx_tag_in : last_tag_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drops_r    <= '0;
      txcnt_r    <= '0;
      last_tag_r <= '0;
    end else if (pclk_en) begin
      drops_r    <= drops_nxt;
      txcnt_r    <= txcnt_nxt;
      last_tag_r <= last_tag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states, error on unmapped addresses.

  logic        setup, mapped, wr_ctrl;
  logic [31:0] rd_word;
  logic [31:0] prdata_r, prdata_nxt;

  assign setup   = psel && !penable;
  assign pready  = 1'b1;
  assign mapped  = (paddr == `PTS_ADDR_CTRL) || (paddr == `PTS_ADDR_STATUS) ||
                   (paddr == `PTS_ADDR_DROPS) || (paddr == `PTS_ADDR_TXCNT);
  assign pslverr = psel && penable && !mapped;
  assign wr_ctrl = psel && penable && pwrite && pstrb[0] && (paddr == `PTS_ADDR_CTRL);

  always_comb begin
    unique case (paddr)
      `PTS_ADDR_CTRL:   rd_word = {29'h0, ctrl_r};
      `PTS_ADDR_STATUS: rd_word = {13'h0, q_full, !q_empty, txv_r, last_tag_r};
      `PTS_ADDR_DROPS:  rd_word = {16'h0, drops_r};
      `PTS_ADDR_TXCNT:  rd_word = {16'h0, txcnt_r};
      default:          rd_word = 32'h0;
    endcase
    prdata_nxt = (setup && !pwrite) ? rd_word : prdata_r;
    ctrl_nxt   = wr_ctrl ? pwdata[`PTS_CTRL_W-1:0] : ctrl_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      ctrl_r   <= `PTS_CTRL_RST;
    end else if (pclk_en) begin
      prdata_r <= prdata_nxt;
      ctrl_r   <= ctrl_nxt;
    end
  end

  assign prdata = prdata_r;

endmodule // pts_top

// ---- tb/pts_checker.sv ----
`timescale 1ns/1ns
`include "pts_consts.svh"

module pts_checker (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic [`PTS_TIME_W-1:0]  sys_time,
  input wire logic                    tx_sop,
  input wire logic [1:0]              timestamp_op_code,
  input wire logic [`PTS_TAG_W-1:0]   tx_tag_in,
  input wire logic [`PTS_OFS_W-1:0]   tx_ts_offset_in,
  input wire logic [`PTS_OFS_W-1:0]   tx_csum_offset_in,
  input wire logic                    tx_upd_csum_in,
  input wire logic                    tx_tstamp_valid,
  input wire logic [`PTS_TIME_W-1:0]  tx_tstamp,
  input wire logic [`PTS_TAG_W-1:0]   tx_tstamp_tag,
  input wire logic                    onestep_valid,
  input wire logic [`PTS_TIME_W-1:0]  onestep_time,
  input wire logic [`PTS_OFS_W-1:0]   onestep_ts_offset,
  input wire logic [`PTS_OFS_W-1:0]   onestep_csum_offset,
  input wire logic                    onestep_upd_csum,
  input wire logic                    rx_sop,
  input wire logic [`PTS_TIME_W-1:0]  rx_tstamp
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_tx_stamp_due: assert property ((tx_sop && timestamp_op_code inside {`PTS_OP_ONESTEP,
    `PTS_OP_TWOSTEP}) |-> ##2 tx_tstamp_valid) else $error("stamp valid missing");
  a_tx_stamp_cause: assert property (tx_tstamp_valid |-> $past(tx_sop, 2) &&
    $past(timestamp_op_code, 2) inside {`PTS_OP_ONESTEP, `PTS_OP_TWOSTEP})
    else $error("stamp without stamped frame");
  a_tag_returned: assert property ((tx_sop && timestamp_op_code inside {`PTS_OP_ONESTEP,
    `PTS_OP_TWOSTEP}) |-> ##2 tx_tstamp_tag == $past(tx_tag_in, 2))
    else $error("returned tag differs");
  a_time_returned: assert property ((tx_sop && timestamp_op_code inside {`PTS_OP_ONESTEP,
    `PTS_OP_TWOSTEP}) |-> ##2 tx_tstamp == $past(sys_time, 2))
    else $error("returned stamp differs");
  a_rx_same_cycle: assert property (rx_sop |-> rx_tstamp == sys_time)
    else $error("receive stamp late");
  a_rx_stamp_held: assert property (!rx_sop |-> $stable(rx_tstamp))
    else $error("receive stamp moved");
  a_onestep_cause: assert property (onestep_valid |-> $past(tx_sop) &&
    $past(timestamp_op_code) == `PTS_OP_ONESTEP) else $error("one-step without cause");
  a_onestep_fields: assert property (onestep_valid |-> onestep_time == $past(sys_time) &&
    onestep_ts_offset == $past(tx_ts_offset_in) && onestep_csum_offset ==
    $past(tx_csum_offset_in) && onestep_upd_csum == $past(tx_upd_csum_in))
    else $error("one-step fields differ");
endmodule // pts_checker

bind pts_top pts_checker chk (.pclk(pclk), .presetn(presetn), .sys_time(sys_time),
  .tx_sop(tx_sop), .timestamp_op_code(timestamp_op_code), .tx_tag_in(tx_tag_in),
  .tx_ts_offset_in(tx_ts_offset_in), .tx_csum_offset_in(tx_csum_offset_in),
  .tx_upd_csum_in(tx_upd_csum_in), .tx_tstamp_valid(tx_tstamp_valid), .tx_tstamp(tx_tstamp),
  .tx_tstamp_tag(tx_tstamp_tag), .onestep_valid(onestep_valid), .onestep_time(onestep_time),
  .onestep_ts_offset(onestep_ts_offset), .onestep_csum_offset(onestep_csum_offset),
  .onestep_upd_csum(onestep_upd_csum), .rx_sop(rx_sop), .rx_tstamp(rx_tstamp));

// ---- tb/pts_client_model.sv ----
`timescale 1ns/1ns

module pts_client_model (
  input  wire logic          pclk,
  output logic               tx_sop,
  output logic [1:0]         timestamp_op_code,
  output logic [15:0]        tx_tag_in,
  output logic [15:0]        tx_ts_offset_in,
  output logic [15:0]        tx_csum_offset_in,
  output logic               tx_upd_csum_in,
  output pts_pkg::pts_time_s sys_time
);
  logic [17:0] fq[$];
  logic [95:0] expq[$];
  int          stamped;
  logic [17:0] f;
  logic        have;
  logic [15:0] last_tag = 16'h0;

  initial begin
    {tx_sop, timestamp_op_code, tx_tag_in, tx_ts_offset_in} = 35'h0;
    {tx_csum_offset_in, tx_upd_csum_in} = 17'h0;
    sys_time = {48'h0, 32'h3b9ac99c};
    stamped = 0;
  end

  // Frames leave one per cycle; idle cycles flip every qualifier so stale values never match.
  always @(posedge pclk) begin
    if (sys_time.ns >= 32'h3b9ac9f6) begin
      sys_time <= {sys_time.sec + 48'h1, 32'h0};
    end else begin
      sys_time.ns <= sys_time.ns + 32'ha;
    end
    if (tx_sop && timestamp_op_code inside {2'h1, 2'h2}) begin
      expq.push_back({sys_time, tx_tag_in});
      last_tag = tx_tag_in;
      stamped++;
    end
    have = (fq.size() != 0);
    f = have ? fq.pop_front() : {~timestamp_op_code, ~tx_tag_in};
    tx_sop <= have;
    {timestamp_op_code, tx_tag_in} <= f;
    {tx_ts_offset_in, tx_csum_offset_in} <= {f[7:0], f[15:8], ~f[15:0]};
    tx_upd_csum_in <= f[0];
  end
endmodule // pts_client_model

// ---- tb/pts_top_tb.sv ----
`timescale 1ns/1ns
`include "pts_consts.svh"
`define CHK(n, e, a) begin total_checks++; if ((e) !== (a)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end

module pts_top_tb;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        tx_sop, upd, tsv, osv, rx_sop;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [31:0] rseed = 32'h16baf1ea;
  logic [1:0]  op;
  logic [15:0] tag, tso, cso, ttag;
  logic [79:0] tts, rxt;
  logic [95:0] ex;
  pts_pkg::pts_time_s st;
  int          error_cnt = 0, total_checks = 0, cyc = 0, osn = 0, i;

  always #5 pclk = ~pclk;

  pts_top dut (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .sys_time(st), .tx_sop(tx_sop),
    .timestamp_op_code(op), .tx_tag_in(tag), .tx_ts_offset_in(tso), .tx_csum_offset_in(cso),
    .tx_upd_csum_in(upd), .tx_tstamp_valid(tsv), .tx_tstamp(tts), .tx_tstamp_tag(ttag),
    .onestep_valid(osv), .onestep_time(), .onestep_ts_offset(), .onestep_csum_offset(),
    .onestep_upd_csum(), .rx_sop(rx_sop), .rx_tstamp(rxt));

  pts_client_model cli (.pclk(pclk), .tx_sop(tx_sop), .timestamp_op_code(op), .tx_tag_in(tag),
    .tx_ts_offset_in(tso), .tx_csum_offset_in(cso), .tx_upd_csum_in(upd), .sys_time(st));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Frames go back to back; with the clock enabled each stamp returns two edges later.
  task frames(input int cnt, input logic rnd);
    for (int j = 0; j < cnt; j++) begin
      seed = lfsr(seed);
      cli.fq.push_back({rnd ? seed[17:16] : j[1:0], seed[15:0]});
    end
    repeat (cnt + 6) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    rseed <= lfsr(rseed);
    rx_sop <= presetn & rseed[3];
    osn <= osn + int'(osv === 1'b1);
    if (presetn && rx_sop === 1'b1) begin
      `CHK("rx_stamp", {st.sec, st.ns}, rxt)
    end
    if (presetn && tsv === 1'b1) begin
      `CHK("stamp_pending", 1'b1, cli.expq.size() != 0)
      ex = (cli.expq.size() != 0) ? cli.expq.pop_front() : 96'h0;
      `CHK("stamp_and_tag", ex, {tts, ttag})
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
    seed = 32'h16baf1ea;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `PTS_ADDR_CTRL, seed);
    `CHK("ctrl_reset", 32'h7, rd)
    frames(16, 1'b0);
    `CHK("onestep_count", 4, osn)
    $display("test op_codes done");
    apb(1'b1, `PTS_ADDR_CTRL, 32'h3);
    i = osn;
    frames(8, 1'b0);
    `CHK("onestep_off", i, osn)
    apb(1'b1, `PTS_ADDR_CTRL, 32'h7);
    $display("test onestep_off done");
    frames(40, 1'b1);
    apb(1'b0, `PTS_ADDR_TXCNT, 32'h0);
    `CHK("frames_stamped", {16'h0, cli.stamped[15:0]}, rd)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    `CHK("stamps_left", 0, cli.expq.size())
    apb(1'b0, `PTS_ADDR_STATUS, 32'h0);
    `CHK("status_idle", {16'h0, cli.last_tag}, rd)
    apb(1'b0, `PTS_ADDR_DROPS, 32'h0);
    `CHK("drops", 32'h0, rd)
    $display("test random_frames done");
    stop_test();
  end
endmodule // pts_top_tb
